// File: rtl/flad_top.sv
// Fault latching, fault pin, clear-on-read status and autoretry of a four-output switch
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// Functional notes
// - Severe short latches output off, pulls fault pin low, sets short flag
// - Severe short releases only by off-on toggle after removal, power-on or logic-supply failure without undervoltage
// - Status read clears the short fault flags
// - Overvoltage with protection on: all outputs off, pin low, flag set
// - Shutdown disabled: overvoltage only flagged; read clears once condition gone
// - Fail-safe mode: overvoltage shutdown follows wake/reset pin level
// - Undervoltage turns outputs off, pulls pin low, sets undervoltage flag
// - Recovery with outputs off releases pin; flag held until read
// - Recovery with output on keeps pin low until retry or toggle
// - Logic-supply failure without undervoltage, or supply power-on, resets latches and short, overcurrent, overtemperature and supply flags
// - Logic supply lost or enabled failure resets registers to defaults
// - Retry request per output from overcurrent, overtemperature or undervoltage
// - Retry after one interval, at most sixteen attempts per output
// - Mode change or retry-disable toggle clears attempt counters
// - Every retry restores the inrush overcurrent profile
// - Short to supply on off output sets both flags; pin real time
// - Short-to-supply check disabled per output by a register bit
// - Off-state open load sets flag, clears on read, disable per output
// - On-state open load sets flag, output and pin untouched
// - LED mode checks once per period, fully on, after one period
// - Normal mode latches temperature prewarning, cleared only by read
// - Supply clamp cancels turn-off and switches all outputs on
// - First status read returns latched faults and clears them
module flad_top
	import flad_pkg::*;
#(
	parameter int unsigned RETRY_US = flad_pkg::RETRY_INTERVAL_US,
	parameter int unsigned LED_US = flad_pkg::LED_CHECK_US
) (
	input wire logic sys_clk, // 20 MHz system clock
	input wire logic resetn, // Synchronous reset, active low
	input wire logic [flad_pkg::ADDR_W-1:0] addr, // Register address
	input wire logic [flad_pkg::DATA_W-1:0] wdata, // Write data
	input wire logic wr_en, // Write strobe
	input wire logic rd_en, // Read strobe
	output logic [flad_pkg::DATA_W-1:0] rdata, // Read data, cycle after strobe
	input wire logic [flad_pkg::NUM_OUT-1:0] sev_short_det, // Severe short seen
	input wire logic [flad_pkg::NUM_OUT-1:0] overcurrent_det, // Overcurrent seen
	input wire logic [flad_pkg::NUM_OUT-1:0] overtemp_det, // Overtemperature seen
	input wire logic [flad_pkg::NUM_OUT-1:0] short_supply_det, // Output above short level
	input wire logic [flad_pkg::NUM_OUT-1:0] open_off_det, // Off-state open load seen
	input wire logic [flad_pkg::NUM_OUT-1:0] open_on_det, // Load current below threshold
	input wire logic overvoltage_det, // Battery supply overvoltage
	input wire logic undervoltage_det, // Battery supply undervoltage
	input wire logic clamp_det, // Battery supply above clamp level
	input wire logic temp_warn_det, // Ground flag above warning level
	input wire logic logic_supply_fail, // Logic supply below fail level
	input wire logic logic_supply_lost, // Logic supply disconnected
	input wire logic supply_por, // Both supplies below power-on level
	input wire logic wake_reset_pin, // Wake/reset pin level
	input wire logic fail_safe_mode, // Device in fail-safe mode
	output logic [flad_pkg::NUM_OUT-1:0] switched_outputs, // Gate enables
	output logic fault_flag_pin_n, // Fault flag pin, low on fault
	output logic [flad_pkg::NUM_OUT-1:0] inrush_restore // Pulse: default inrush profile
);
	localparam int unsigned SYNC_W = 6 * NUM_OUT + 9;
	localparam logic [4:0] US_LAST = 5'(US_CYCLES - 1);
	localparam logic [TIMER_W-1:0] LED_LAST = TIMER_W'(LED_US - 1);

	typedef struct packed {
		logic [2:0] ctrl;
		logic [NUM_OUT-1:0] os_dis;
		logic [NUM_OUT-1:0] oloff_dis;
		logic [NUM_OUT-1:0] open_load_on_flag_dis;
		logic [NUM_OUT-1:0] led_sel;
		logic [NUM_OUT-1:0] cmd_on;
		logic [NUM_OUT-1:0] duty_full;
		logic [NUM_OUT-1:0] cmd_prev;
		logic [NUM_OUT-1:0] sc_flags;
		logic [NUM_OUT-1:0] oc_flags;
		logic [NUM_OUT-1:0] ot_flags;
		logic [NUM_OUT-1:0] os_flags;
		logic [NUM_OUT-1:0] oloff_flags;
		logic [NUM_OUT-1:0] open_load_on_flag_flags;
		logic ovf;
		logic uvf;
		logic temp_prewarning_flag;
		logic [NUM_OUT-1:0] sc_lat;
		logic [NUM_OUT-1:0] ret_lat;
		logic [NUM_OUT-1:0] led_armed;
		logic mode_prev;
		logic retry_dis_prev;
		logic [4:0] us_div;
		logic tick_us;
		logic [TIMER_W-1:0] led_cnt;
		logic led_tick;
		logic [NUM_OUT-1:0] sw;
		logic fault_n;
		logic [NUM_OUT-1:0] inrush;
		logic [DATA_W-1:0] rdata;
	} flad_state_t;

	localparam flad_state_t ST_RESET = '{fault_n: 1'b1, default: '0};

	flad_state_t q;
	flad_state_t n;
	logic [SYNC_W-1:0] sync_v;
	logic [NUM_OUT-1:0] s_sc, s_oc, s_ot, s_os, s_oloff, s_open_load_on_flag;
	logic s_ov, s_uv, s_clamp, s_otw, s_vfail, s_vlost, s_por, s_wake, s_fs;
	logic [NUM_OUT-1:0] fire;
	logic [NUM_OUT-1:0] exhausted;
	logic [NUM_OUT-1:0] cmd_rise;
	logic ov_en;
	logic ov_shut;
	logic rd_stat;
	logic fault_reset;
	logic reg_reset;
	logic retry_clear_all;

	// ----------------------------------------------------------------
	// Input synchronisation
	// ----------------------------------------------------------------
	flad_sync #(.W(SYNC_W)) u_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.async_in({sev_short_det, overcurrent_det, overtemp_det, short_supply_det,
			open_off_det, open_on_det, overvoltage_det, undervoltage_det, clamp_det,
			temp_warn_det, logic_supply_fail, logic_supply_lost, supply_por,
			wake_reset_pin, fail_safe_mode}),
		.sync_out(sync_v)
	);

	assign {s_sc, s_oc, s_ot, s_os, s_oloff, s_open_load_on_flag, s_ov, s_uv, s_clamp, s_otw,
		s_vfail, s_vlost, s_por, s_wake, s_fs} = sync_v;

	// ----------------------------------------------------------------
	// Shared conditions
	// ----------------------------------------------------------------
	assign cmd_rise = q.cmd_on & ~q.cmd_prev;
	assign ov_en = s_fs ? s_wake : !q.ctrl[CTRL_OVERVOLTAGE_SHUTDOWN_DISABLE];
	assign ov_shut = ov_en && s_ov;
	assign rd_stat = rd_en && (addr == ADR_STATUS);
	assign fault_reset = (s_vfail && !s_uv) || s_por;
	assign reg_reset = s_vlost || (s_vfail && q.ctrl[CTRL_VDD_FAIL_EN]);
	assign retry_clear_all = (s_fs != q.mode_prev) ||
		(q.ctrl[CTRL_RETRY_DIS] != q.retry_dis_prev);

	// ----------------------------------------------------------------
	// Autoretry sequencers, one per output
	// ----------------------------------------------------------------
	for (genvar i = 0; i < NUM_OUT; i++) begin : g_retry
		flad_retry #(.INTERVAL_US(RETRY_US), .MAX_TRIES(RETRY_MAX)) u_retry (
			.sys_clk(sys_clk),
			.resetn(resetn),
			.tick_us(q.tick_us),
			.clear(retry_clear_all || cmd_rise[i] || fault_reset),
			.enable(!q.ctrl[CTRL_RETRY_DIS]),
			.request(q.ret_lat[i] && (q.oc_flags[i] || q.ot_flags[i] || q.uvf)),
			.fire(fire[i]),
			.exhausted(exhausted[i])
		);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [NUM_OUT-1:0] os_set;
		logic [NUM_OUT-1:0] oloff_set;
		logic [NUM_OUT-1:0] open_load_on_flag_set;
		logic [NUM_OUT-1:0] keep;
		logic [NUM_OUT-1:0] gone;
		os_set = '0;
		oloff_set = '0;
		open_load_on_flag_set = '0;
		keep = '0;
		gone = '0;
		n = q;
		n.rdata = '0;
		n.cmd_prev = q.cmd_on;
		n.mode_prev = s_fs;
		n.retry_dis_prev = q.ctrl[CTRL_RETRY_DIS];

		// Microsecond and LED check period dividers
		n.tick_us = (q.us_div == US_LAST);
		n.us_div = n.tick_us ? 5'h00 : q.us_div + 5'h01;
		n.led_tick = 1'b0;
		if (q.tick_us) begin
			n.led_tick = (q.led_cnt == LED_LAST);
			n.led_cnt = n.led_tick ? '0 : q.led_cnt + 16'h0001;
		end

		// Register writes
		if (wr_en) begin
			if (addr == ADR_CTRL) begin
				n.ctrl = wdata[2:0];
			end else if (addr == ADR_DIAG_DIS) begin
				n.os_dis = wdata[DIS_OS +: NUM_OUT];
				n.oloff_dis = wdata[DIS_OLOFF +: NUM_OUT];
				n.open_load_on_flag_dis = wdata[DIS_OPEN_LOAD_ON_FLAG +: NUM_OUT];
				n.led_sel = wdata[DIS_LED +: NUM_OUT];
			end else if (addr == ADR_OUT_CMD) begin
				n.cmd_on = wdata[CMD_ON +: NUM_OUT];
				n.duty_full = wdata[CMD_FULL +: NUM_OUT];
			end
		end

		// Register reads, status snapshot before the clear
		if (rd_en) begin
			if (addr == ADR_STATUS) begin
				n.rdata[STAT_SC +: NUM_OUT] = q.sc_flags;
				n.rdata[STAT_OC +: NUM_OUT] = q.oc_flags;
				n.rdata[STAT_OT +: NUM_OUT] = q.ot_flags;
				n.rdata[STAT_OS +: NUM_OUT] = q.os_flags;
				n.rdata[STAT_OLOFF +: NUM_OUT] = q.oloff_flags;
				n.rdata[STAT_OPEN_LOAD_ON_FLAG +: NUM_OUT] = q.open_load_on_flag_flags;
				n.rdata[STAT_OVF] = q.ovf;
				n.rdata[STAT_UV] = q.uvf;
				n.rdata[STAT_OTW] = q.temp_prewarning_flag;
			end else if (addr == ADR_CTRL) begin
				n.rdata[2:0] = q.ctrl;
			end else if (addr == ADR_DIAG_DIS) begin
				n.rdata[15:0] = {q.led_sel, q.open_load_on_flag_dis, q.oloff_dis, q.os_dis};
			end else if (addr == ADR_OUT_CMD) begin
				n.rdata[7:0] = {q.duty_full, q.cmd_on};
			end else if (addr == ADR_STATE) begin
				n.rdata[STATE_SW +: NUM_OUT] = q.sw;
				n.rdata[STATE_LAT +: NUM_OUT] = q.sc_lat | q.ret_lat;
				n.rdata[STATE_EXH +: NUM_OUT] = exhausted;
				n.rdata[STATE_FS] = s_fs;
			end
		end

		// Diagnostic set terms
		keep = rd_stat ? '0 : '1;
		os_set = s_os & ~q.sw & ~q.os_dis;
		oloff_set = os_set | (s_oloff & ~q.sw & ~q.oloff_dis);
		for (int i = 0; i < NUM_OUT; i++) begin
			if (!(q.sw[i] && q.duty_full[i])) begin
				n.led_armed[i] = 1'b0;
			end else if (q.led_tick) begin
				n.led_armed[i] = 1'b1;
			end
			if (q.led_sel[i]) begin
				open_load_on_flag_set[i] = q.led_tick && q.led_armed[i] && q.duty_full[i] && q.sw[i] &&
					s_open_load_on_flag[i] && !q.open_load_on_flag_dis[i];
			end else begin
				open_load_on_flag_set[i] = q.sw[i] && s_open_load_on_flag[i] && !q.open_load_on_flag_dis[i];
			end
		end

		// Sticky flags: a set in the clearing cycle wins
		n.sc_flags = s_sc | (q.sc_flags & keep);
		n.oc_flags = s_oc | (q.oc_flags & keep);
		n.ot_flags = s_ot | (q.ot_flags & keep);
		n.os_flags = os_set | (q.os_flags & keep);
		n.oloff_flags = oloff_set | (q.oloff_flags & keep);
		n.open_load_on_flag_flags = open_load_on_flag_set | (q.open_load_on_flag_flags & keep);
		n.ovf = s_ov | (q.ovf & !rd_stat);
		n.uvf = s_uv | (q.uvf & !rd_stat);
		n.temp_prewarning_flag = (s_otw && !s_fs) || (q.temp_prewarning_flag && !rd_stat);

		// Output latches: release first, then set
		gone = ~(s_oc | s_ot | {NUM_OUT{s_uv}});
		n.sc_lat = (q.sc_lat & ~(cmd_rise & ~s_sc)) | s_sc;
		n.ret_lat = (q.ret_lat & ~((cmd_rise | fire) & gone)) |
			((s_oc | s_ot | {NUM_OUT{s_uv}}) & q.cmd_on);
		n.inrush = fire | cmd_rise;

		// Supply events
		if (fault_reset) begin
			n.sc_lat = '0;
			n.ret_lat = '0;
			n.sc_flags = '0;
			n.oc_flags = '0;
			n.ot_flags = '0;
			n.ovf = 1'b0;
			n.uvf = 1'b0;
		end
		if (reg_reset) begin
			n.ctrl = CTRL_RST;
			n.os_dis = PER_OUT_RST;
			n.oloff_dis = PER_OUT_RST;
			n.open_load_on_flag_dis = PER_OUT_RST;
			n.led_sel = PER_OUT_RST;
			n.cmd_on = PER_OUT_RST;
			n.duty_full = PER_OUT_RST;
		end

		// Gate drive and fault pin
		if (s_clamp) begin
			n.sw = '1;
		end else begin
			n.sw = n.cmd_on & ~n.sc_lat & ~n.ret_lat & ~{NUM_OUT{s_uv || ov_shut}};
		end
		n.fault_n = !(|n.sc_lat || |n.ret_lat || ov_shut || s_uv ||
			|(s_ot & ~n.cmd_on) || |oloff_set);
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			q <= ST_RESET;
		end else begin
			q <= n;
		end
	end

	assign switched_outputs = q.sw;
	assign fault_flag_pin_n = q.fault_n;
	assign inrush_restore = q.inrush;
	assign rdata = q.rdata;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence seq_stat_read;
		rd_en && (addr == ADR_STATUS);
	endsequence

	sequence seq_no_release0;
		!cmd_rise[0] && !fault_reset;
	endsequence

	AST_SC_LATCH: assert property (s_sc[0] && !s_clamp && !fault_reset |=>
		!switched_outputs[0] && !fault_flag_pin_n && q.sc_flags[0])
		else $error("severe short did not latch output off");
	AST_SC_HOLD: assert property (q.sc_lat[0] and seq_no_release0 |=> q.sc_lat[0])
		else $error("severe short latch released without toggle");
	AST_STAT_CLR: assert property (seq_stat_read and !s_sc[0] |=> !q.sc_flags[0])
		else $error("short flag not cleared by status read");
	AST_STAT_DATA: assert property (seq_stat_read and q.sc_flags[0] |=> rdata[STAT_SC])
		else $error("latched short not returned by status read");
	AST_OV_OFF: assert property (ov_shut && !s_clamp && !fault_reset |=>
		switched_outputs == 4'h0 && !fault_flag_pin_n && q.ovf)
		else $error("overvoltage shutdown missing");
	AST_OV_WARN: assert property (s_ov && !ov_en && !s_clamp && !s_uv && !fault_reset |=>
		q.ovf && switched_outputs == $past(n.cmd_on & ~n.sc_lat & ~n.ret_lat))
		else $error("overvoltage warning wrong");
	AST_FS_OV: assert property (s_fs |-> ov_en == s_wake)
		else $error("fail-safe overvoltage enable wrong");
	AST_UV: assert property (s_uv && !s_clamp && !fault_reset |=>
		!fault_flag_pin_n && q.uvf && switched_outputs == 4'h0)
		else $error("undervoltage response missing");
	AST_RETRY_CAP: assert property (exhausted[0] && !cmd_rise[0] && !retry_clear_all &&
		!fault_reset |=> !fire[0] && exhausted[0])
		else $error("retry beyond limit");
	AST_INRUSH: assert property (fire[0] |=> inrush_restore[0])
		else $error("inrush profile not restored at retry");
	AST_CLAMP: assert property (s_clamp |=> switched_outputs == 4'hF)
		else $error("clamp did not switch all outputs on");
	AST_OTW: assert property (s_otw && !s_fs && !reg_reset |=> q.temp_prewarning_flag)
		else $error("temperature prewarning not latched");
endmodule : flad_top

// File: inc/flad_pkg.sv
// Shared constants, register map and types of the fault latch and autoretry block
package flad_pkg;
	// ----------------------------------------------------------------
	// Sizes and timing
	// ----------------------------------------------------------------
	localparam int unsigned NUM_OUT = 4;
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned US_NS = 1000;
	localparam int unsigned US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RETRY_INTERVAL_US = 5000;
	localparam int unsigned LED_CHECK_US = 1000;
	localparam int unsigned RETRY_MAX = 16;
	localparam int unsigned TIMER_W = 16;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] ADR_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADR_DIAG_DIS = 4'h1;
	localparam logic [ADDR_W-1:0] ADR_OUT_CMD = 4'h2;
	localparam logic [ADDR_W-1:0] ADR_STATUS = 4'h3;
	localparam logic [ADDR_W-1:0] ADR_STATE = 4'h4;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_OVERVOLTAGE_SHUTDOWN_DISABLE = 0;
	localparam int unsigned CTRL_VDD_FAIL_EN = 1;
	localparam int unsigned CTRL_RETRY_DIS = 2;
	localparam int unsigned DIS_OS = 0;
	localparam int unsigned DIS_OLOFF = 4;
	localparam int unsigned DIS_OPEN_LOAD_ON_FLAG = 8;
	localparam int unsigned DIS_LED = 12;
	localparam int unsigned CMD_ON = 0;
	localparam int unsigned CMD_FULL = 4;
	localparam int unsigned STAT_SC = 0;
	localparam int unsigned STAT_OC = 4;
	localparam int unsigned STAT_OT = 8;
	localparam int unsigned STAT_OS = 12;
	localparam int unsigned STAT_OLOFF = 16;
	localparam int unsigned STAT_OPEN_LOAD_ON_FLAG = 20;
	localparam int unsigned STAT_OVF = 24;
	localparam int unsigned STAT_UV = 25;
	localparam int unsigned STAT_OTW = 26;
	localparam int unsigned STATE_SW = 0;
	localparam int unsigned STATE_LAT = 4;
	localparam int unsigned STATE_EXH = 8;
	localparam int unsigned STATE_FS = 12;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam logic [3:0] PER_OUT_RST = 4'h0;

	// ----------------------------------------------------------------
	// Retry sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		RT_IDLE = 3'b001,
		RT_WAIT = 3'b010,
		RT_SPENT = 3'b100
	} flad_retry_state_t;
endpackage : flad_pkg

// File: rtl/flad_sync.sv
// Two-stage synchroniser for the comparator and pin inputs
`timescale 1ns/1ps
module flad_sync #(
	parameter int unsigned W = 8
) (
	input wire logic sys_clk, // System clock
	input wire logic resetn, // Synchronous reset, active low
	input wire logic [W-1:0] async_in, // Inputs from outside the clock domain
	output logic [W-1:0] sync_out // Synchronised copy
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} flad_sync_t;

	flad_sync_t q;
	flad_sync_t n;

	always_comb begin
		n.meta = async_in;
		n.stable = q.meta;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign sync_out = q.stable;
endmodule : flad_sync

// File: rtl/flad_retry.sv
// Autoretry sequencer for one output: interval timer and attempt counter
`timescale 1ns/1ps
module flad_retry
	import flad_pkg::*;
#(
	parameter int unsigned INTERVAL_US = flad_pkg::RETRY_INTERVAL_US,
	parameter int unsigned MAX_TRIES = flad_pkg::RETRY_MAX
) (
	input wire logic sys_clk, // System clock
	input wire logic resetn, // Synchronous reset, active low
	input wire logic tick_us, // One-cycle pulse every microsecond
	input wire logic clear, // Restart count and attempts
	input wire logic enable, // Autoretry allowed
	input wire logic request, // Output latched off with a retry cause
	output logic fire, // One-cycle pulse: attempt a restart
	output logic exhausted // All attempts used
);
	// Partial first microsecond plus a full interval before the first attempt
	localparam logic [TIMER_W-1:0] LAST_US = TIMER_W'(INTERVAL_US);
	localparam logic [4:0] TRY_LAST = 5'(MAX_TRIES);

	typedef struct packed {
		flad_retry_state_t state;
		logic [TIMER_W-1:0] cnt;
		logic [4:0] tries;
		logic fire;
	} flad_rt_t;

	flad_rt_t q;
	flad_rt_t n;

	always_comb begin
		n = q;
		n.fire = 1'b0;
		case (q.state)
			RT_IDLE: begin
				n.cnt = '0;
				if (enable && request) begin
					n.state = RT_WAIT;
				end
			end
			RT_WAIT: begin
				if (!enable || !request) begin
					n.state = RT_IDLE;
				end else if (tick_us) begin
					if (q.cnt == LAST_US) begin
						// Firing tick already opens the next interval
						n.cnt = TIMER_W'(1);
						n.fire = 1'b1;
						n.tries = q.tries + 5'h1;
						if (n.tries == TRY_LAST) begin
							n.state = RT_SPENT;
						end
					end else begin
						n.cnt = q.cnt + 16'h0001;
					end
				end
			end
			RT_SPENT: begin
				n.cnt = '0;
			end
			default: begin
				n.state = RT_IDLE;
			end
		endcase
		if (clear) begin
			n.state = RT_IDLE;
			n.cnt = '0;
			n.tries = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			q <= '{state: RT_IDLE, default: '0};
		end else begin
			q <= n;
		end
	end

	assign fire = q.fire;
	assign exhausted = (q.state == RT_SPENT);
endmodule : flad_retry

// File: dv/flad_host.sv
// Host model: register bus master facing the fault block
`timescale 1ns/1ps
module flad_host
	import flad_pkg::*;
(
	input wire logic sys_clk, // System clock
	output logic [flad_pkg::ADDR_W-1:0] addr, // Register address
	output logic [flad_pkg::DATA_W-1:0] wdata, // Write data
	output logic wr_en, // Write strobe
	output logic rd_en, // Read strobe
	input wire logic [flad_pkg::DATA_W-1:0] rdata // Read data
);
	initial begin
		addr = 4'h0;
		wdata = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
	end
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge sys_clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge sys_clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		@(posedge sys_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		#1;
		v = rdata;
	endtask : rd
	// Off then on restarts a latched output
	task automatic toggle(input logic [DATA_W-1:0] cmd);
		wr(ADR_OUT_CMD, 32'h0);
		wr(ADR_OUT_CMD, cmd);
	endtask : toggle
endmodule : flad_host

// File: dv/flad_test.sv
// Self-checking bench of the fault latch and autoretry block
`timescale 1ns/1ps
module flad_test;
	import flad_pkg::*;
	typedef struct {
		logic [15:0] det;
		logic [3:0] lvl;
		logic [3:0] sw;
		logic [31:0] st;
	} flad_row_t;
	logic sys_clk, resetn, wr_en, rd_en, fail_safe_mode, wake_reset_pin;
	logic overvoltage_det, undervoltage_det, clamp_det, temp_warn_det, fault_flag_pin_n;
	logic logic_supply_fail, logic_supply_lost, supply_por;
	logic [3:0] addr, sev_short_det, overcurrent_det, overtemp_det, short_supply_det;
	logic [3:0] open_off_det, open_on_det, switched_outputs, inrush_restore;
	logic [31:0] wdata, rdata, d;
	int num_errors, n_checks, n, f;
	flad_row_t rows [7];

	flad_top #(.RETRY_US(3), .LED_US(2)) u_dut (.sys_clk(sys_clk), .resetn(resetn),
		.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.sev_short_det(sev_short_det), .overcurrent_det(overcurrent_det),
		.overtemp_det(overtemp_det), .short_supply_det(short_supply_det),
		.open_off_det(open_off_det), .open_on_det(open_on_det),
		.overvoltage_det(overvoltage_det), .undervoltage_det(undervoltage_det),
		.clamp_det(clamp_det), .temp_warn_det(temp_warn_det),
		.logic_supply_fail(logic_supply_fail), .logic_supply_lost(logic_supply_lost),
		.supply_por(supply_por), .wake_reset_pin(wake_reset_pin),
		.fail_safe_mode(fail_safe_mode), .switched_outputs(switched_outputs),
		.fault_flag_pin_n(fault_flag_pin_n), .inrush_restore(inrush_restore));
	flad_host u_host (.sys_clk(sys_clk), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata));

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic cy(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask : cy
	task automatic quiet(input bit e);
		if (e) @(posedge sys_clk);
		{sev_short_det, overcurrent_det, overtemp_det, short_supply_det} <= 16'h0;
		{open_off_det, open_on_det, fail_safe_mode, wake_reset_pin} <= 10'h0;
		{overvoltage_det, undervoltage_det, clamp_det, temp_warn_det} <= 4'h0;
		{logic_supply_lost, supply_por, logic_supply_fail} <= 3'h0;
	endtask : quiet
	// Counts restart pulses of one output, f is the cycle of the first
	task automatic watch(input int idx, input int len);
		n = 0;
		f = 0;
		for (int t = 1; t <= len; t++) begin
			cy(1);
			f = (n == 0 && inrush_restore[idx] === 1'b1) ? t : f;
			n += int'(inrush_restore[idx] === 1'b1);
		end
	endtask : watch
	task automatic complete_run;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : complete_run

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		num_errors = 0;
		n_checks = 0;
		resetn <= 1'b0;
		quiet(0);
		rows = '{'{16'h1000, 4'h0, 4'hE, 32'h1}, '{16'h0200, 4'h0, 4'hD, 32'h20},
			'{16'h0040, 4'h0, 4'hB, 32'h400}, '{16'h0, 4'h8, 4'h0, 32'h100_0000},
			'{16'h0, 4'h4, 4'h0, 32'h200_0000}, '{16'h0, 4'h3, 4'hF, 32'h400_0000},
			'{16'h0008, 4'h1, 4'hF, 32'h80_0000}};
		repeat (20) @(posedge sys_clk);
		resetn <= 1'b1;
		cy(1);
		chk({rdata[27:0], switched_outputs}, 32'h0);
		chk({inrush_restore, fault_flag_pin_n}, 32'h1);
		for (int a = 0; a < 6; a++) begin
			u_host.rd(4'(a), d);
			chk(d, 32'h0);
		end
		u_host.wr(ADR_STATUS, 32'hFFFF_FFFF);
		u_host.wr(4'h5, 32'hFFFF_FFFF);
		u_host.wr(ADR_DIAG_DIS, 32'hFFFF_FFFF);
		u_host.rd(ADR_DIAG_DIS, d);
		chk(d, 32'hFFFF);
		u_host.wr(ADR_DIAG_DIS, 32'h0);
		u_host.rd(ADR_STATUS, d);
		chk(d, 32'h0);
		foreach (rows[i]) begin
			u_host.wr(ADR_OUT_CMD, 32'hF);
			@(posedge sys_clk);
			{sev_short_det, overcurrent_det, overtemp_det, open_on_det} <= rows[i].det;
			{overvoltage_det, undervoltage_det, temp_warn_det} <= rows[i].lvl[3:1];
			cy(5);
			chk(32'(switched_outputs), 32'(rows[i].sw));
			chk(32'(fault_flag_pin_n), 32'(rows[i].lvl[0]));
			quiet(1);
			cy(5);
			u_host.rd(ADR_STATUS, d);
			chk(d, rows[i].st);
			u_host.rd(ADR_STATUS, d);
			chk(d, 32'h0);
			u_host.toggle(32'hF);
			cy(3);
			chk(32'(switched_outputs), 32'hF);
		end
		u_host.wr(ADR_CTRL, 32'h4);
		u_host.wr(ADR_CTRL, 32'h0);
		@(posedge sys_clk);
		overcurrent_det <= 4'h2;
		watch(1, 1800);
		chk(32'(f inside {[55:90]}), 32'h1);
		chk(32'(n), 32'h10);
		chk(32'(switched_outputs), 32'hD);
		quiet(1);
		u_host.rd(ADR_STATUS, d);
		u_host.toggle(32'hF);
		@(posedge sys_clk);
		sev_short_det <= 4'h1;
		watch(0, 150);
		chk(32'(switched_outputs), 32'hE);
		quiet(1);
		watch(0, 150);
		chk(32'(n), 32'h0);
		chk(32'(switched_outputs), 32'hE);
		@(posedge sys_clk);
		supply_por <= 1'b1;
		cy(3);
		quiet(1);
		cy(3);
		u_host.rd(ADR_STATUS, d);
		chk(d, 32'h0);
		chk(32'(switched_outputs), 32'hF);
		u_host.wr(ADR_CTRL, 32'h1);
		u_host.toggle(32'hF);
		@(posedge sys_clk);
		overvoltage_det <= 1'b1;
		cy(5);
		chk(32'(switched_outputs), 32'hF);
		u_host.rd(ADR_STATUS, d);
		chk(d, 32'h100_0000);
		quiet(1);
		cy(5);
		u_host.rd(ADR_STATUS, d);
		chk(d, 32'h100_0000);
		u_host.rd(ADR_STATUS, d);
		chk(d, 32'h0);
		u_host.wr(ADR_CTRL, 32'h0);
		@(posedge sys_clk);
		{fail_safe_mode, overvoltage_det} <= 2'h3;
		cy(5);
		chk(32'(fault_flag_pin_n), 32'h1);
		@(posedge sys_clk);
		wake_reset_pin <= 1'b1;
		cy(5);
		chk(32'(fault_flag_pin_n), 32'h0);
		quiet(1);
		cy(5);
		u_host.rd(ADR_STATUS, d);
		u_host.wr(ADR_OUT_CMD, 32'h0);
		for (int j = 0; j < 4; j++) begin
			u_host.wr(ADR_DIAG_DIS, j[1] ? 32'(j[0]) << 2 : 32'(j[0]) << 5);
			@(posedge sys_clk);
			open_off_det <= j[1] ? 4'h0 : 4'h2;
			short_supply_det <= j[1] ? 4'h4 : 4'h0;
			cy(5);
			chk(32'(fault_flag_pin_n), 32'(j[0]));
			quiet(1);
			cy(5);
			u_host.rd(ADR_STATUS, d);
			chk(d, j[0] ? 32'h0 : j[1] ? 32'h4_4000 : 32'h2_0000);
		end
		// LED open-load check: flagged only when fully on
		u_host.wr(ADR_DIAG_DIS, 32'h1000);
		for (int k = 0; k < 2; k++) begin
			u_host.wr(ADR_OUT_CMD, k ? 32'h1 : 32'h11);
			@(posedge sys_clk);
			open_on_det <= 4'h1;
			cy(200);
			chk(32'({switched_outputs, fault_flag_pin_n}), 32'h3);
			quiet(1);
			cy(5);
			u_host.rd(ADR_STATUS, d);
			chk(d, k ? 32'h0 : 32'h10_0000);
		end
		u_host.wr(ADR_CTRL, 32'h7);
		@(posedge sys_clk);
		clamp_det <= 1'b1;
		cy(5);
		chk(32'(switched_outputs), 32'hF);
		@(posedge sys_clk);
		clamp_det <= 1'b0;
		logic_supply_lost <= 1'b1;
		cy(5);
		quiet(1);
		u_host.rd(ADR_CTRL, d);
		chk(d, 32'h0);
		u_host.rd(ADR_OUT_CMD, d);
		chk(d, 32'h0);
		complete_run();
	end
endmodule : flad_test
